//--- verilog/rtc_regs.svh
// Register indices, field positions, reset values and timing counts of the calendar clock
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// --------------------------------------------------------------
// Register indices (address port value)
// --------------------------------------------------------------
`define RTC_IDX_SEC 5'h00
`define RTC_IDX_MIN 5'h01
`define RTC_IDX_HOUR 5'h02
`define RTC_IDX_DAY 5'h04
`define RTC_IDX_DATE 5'h05
`define RTC_IDX_MONTH 5'h06
`define RTC_IDX_YEAR 5'h07
`define RTC_IDX_PAGE 5'h08
`define RTC_IDX_RESET 5'h0c
`define RTC_IDX_STAT 5'h10
`define RTC_IDX_MASK 5'h11

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define RTC_PG_PAGE 0
`define RTC_PG_AEN 2
`define RTC_PG_CEN 3
`define RTC_PG_ADJ 4
`define RTC_PG_IEN 7
`define RTC_RS_ACLR 4
`define RTC_RS_DCLR 5
`define RTC_ST_ALARM 0
`define RTC_ST_SEC 1

// --------------------------------------------------------------
// Reset values, don't-care codes and timing
// --------------------------------------------------------------
`define RTC_TAPS_RST 5'h1f
`define RTC_ANY_MIN 7'h7f
`define RTC_ANY_HOUR 6'h3f
`define RTC_ANY_DAY 3'h7
`define RTC_ANY_DATE 6'h3f
`define RTC_OSC_HZ 32768

`endif

//--- verilog/rtc_pkg.sv
// Types shared by the calendar clock modules
`default_nettype none
package rtc_pkg;

  // --------------------------------------------------------------
  // Register bus request
  // --------------------------------------------------------------
  typedef struct packed {
    logic [4:0] addr;  // Register index
    logic [7:0] wdata; // Write data
    logic wr;          // Write strobe
    logic rd;          // Read strobe
  } rtc_bus_req_t;

  // Page selection of the shared addresses
  typedef enum logic {
    RTC_CLOCK_PAGE = 1'b0,
    RTC_ALARM_PAGE = 1'b1
  } rtc_page_t;

endpackage

`default_nettype wire

//--- verilog/rtc_prescale.sv
// Oscillator synchroniser and divider producing the one-second tick and tap clocks
`timescale 1ns/100ps
`default_nettype none
`include "rtc_regs.svh"

module rtc_prescale #(
  parameter int unsigned DIV_EDGES = `RTC_OSC_HZ
) (
  input wire logic clk_sys,   // System clock
  input wire logic rst_n,     // Async reset, low
  input wire logic osc_in,    // Low-speed oscillator pin
  input wire logic clear,     // Divider restart pulse
  output logic tick_1hz,      // One-second pulse
  output logic [4:0] taps     // 1,2,4,8,16 Hz levels, bit0 = 1 Hz
);

  logic [2:0] sync_r;   // Three-stage synchroniser
  logic stable_r;       // Accepted oscillator level
  logic [14:0] cnt_r;   // Edge counter
  logic rise;           // Accepted rising edge

  // --------------------------------------------------------------
  // Synchroniser: only stage 1 reads stage 0
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], osc_in};
    end
  end

  // Change accepted once second and third stage agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stable_r <= 1'b0;
    end else if (sync_r[1] == sync_r[2]) begin
      stable_r <= sync_r[2];
    end
  end

  assign rise = (sync_r[1] == sync_r[2]) & sync_r[2] & ~stable_r;

  // --------------------------------------------------------------
  // Divider; clear restarts the second so software can align it
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 15'h0000;
      tick_1hz <= 1'b0;
    end else begin
      tick_1hz <= rise & (cnt_r == 15'(DIV_EDGES - 1)) & ~clear;
      if (clear) begin
        cnt_r <= 15'h0000;
      end else if (rise) begin
        cnt_r <= (cnt_r == 15'(DIV_EDGES - 1)) ? 15'h0000 : cnt_r + 15'h0001;
      end
    end
  end

  // Counter bits give the tap frequencies at the nominal division
  assign taps = {cnt_r[10], cnt_r[11], cnt_r[12], cnt_r[13], cnt_r[14]};

endmodule

`default_nettype wire

//--- verilog/rtc_top.sv
// Register layer and BCD time/calendar counter of the real-time clock
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_regs.svh"

// Behaviour
// - Reset clears page, seconds_request_a, enable and clear bits, and sets all tap disable bits
// - Time, calendar, alarm registers keep value on reset
// - Seconds are 7-bit BCD, bit 7 reads zero
// - Clock page reads return running count snapshot
// - Alarm page reads return current setting values, zero at the seconds index
// - Weekday in low three bits, upper bits zero
module rtc_top #(
  parameter int unsigned DIV_EDGES = `RTC_OSC_HZ
) (
  input wire logic clk_sys,                // System clock, 250 MHz
  input wire logic rst_n,                  // Async reset, low
  input wire rtc_pkg::rtc_bus_req_t bus,   // Register request
  output logic [7:0] rd_data,              // Read data, cycle after strobe
  input wire logic osc_in,                 // Low-speed oscillator pin
  output logic [4:0] tap_out,              // Divider taps, bit0 = 1 Hz
  output logic irq                         // Level interrupt
);
  import rtc_pkg::*;

  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  logic [6:0] sec_r;       // Running seconds, BCD
  logic [6:0] min_r;       // Running minutes, BCD
  logic [5:0] hour_r;      // Running hours, BCD
  logic [2:0] wday_r;      // Running weekday 0-6
  logic [5:0] date_r;      // Running date, BCD
  logic [4:0] month_r;     // Running month, BCD
  logic [7:0] year_r;      // Running year, BCD
  logic [1:0] leap_r;      // Years since leap year
  logic h24_r;             // 1 = 24-hour mode
  logic [6:0] al_min_r;    // Alarm minutes
  logic [5:0] al_hour_r;   // Alarm hours
  logic [2:0] al_wday_r;   // Alarm weekday
  logic [5:0] al_date_r;   // Alarm date
  rtc_page_t page_r;       // Page select
  logic ien_r;             // Alarm interrupt enable
  logic aen_r;             // Alarm compare enable
  logic cen_r;             // Clock run enable
  logic adj_r;             // Seconds seconds_request_a pending
  logic [4:0] tap_off_r;   // Tap disables, bit0 = 1 Hz
  logic [1:0] stat_r;      // Sticky event status
  logic [1:0] mask_r;      // Interrupt mask

  // --------------------------------------------------------------
  // Next values and strobes
  // --------------------------------------------------------------
  logic [6:0] sec_nxt;
  logic [6:0] min_nxt;
  logic [5:0] hour_nxt;
  logic [2:0] wday_nxt;
  logic [5:0] date_nxt;
  logic [4:0] month_nxt;
  logic [7:0] year_nxt;
  logic [1:0] leap_nxt;
  logic [7:0] rd_nxt;      // Read mux output
  logic tick;              // One-second pulse
  logic [4:0] taps;        // Raw tap levels
  logic sec_step;          // Second advances this cycle
  logic c_min;             // Carry into minutes
  logic c_hour;            // Carry into hours
  logic c_day;             // Carry into day
  logic c_mon;             // Carry into month
  logic c_year;            // Carry into year
  logic [5:0] last_day;    // Last date of current month
  logic alarm_hit;         // Alarm compare event
  logic clk_pg;            // Clock page selected
  logic w_page;            // Write to page register
  logic w_rst;             // Write to reset register
  logic w_stat;            // Write to status register
  logic dclr;              // Divider clear pulse
  logic aclr;              // Alarm clear pulse

  // Step one BCD field, wrapping from top to lo
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
                                          input logic [7:0] lo);
    if (v == top) begin
      bcd_step = lo;
    end else if (v[3:0] == 4'h9) begin
      bcd_step = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_step = v + 8'h01;
    end
  endfunction

  // --------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------
  rtc_prescale #(
    .DIV_EDGES(DIV_EDGES)
  ) u_pre (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .osc_in(osc_in),
    .clear(dclr),
    .tick_1hz(tick),
    .taps(taps)
  );

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  assign clk_pg = (page_r == RTC_CLOCK_PAGE);
  assign w_page = bus.wr && (bus.addr == `RTC_IDX_PAGE);
  assign w_rst = bus.wr && (bus.addr == `RTC_IDX_RESET);
  assign w_stat = bus.wr && (bus.addr == `RTC_IDX_STAT);
  // Clear commands act once and are never stored
  assign dclr = w_rst && bus.wdata[`RTC_RS_DCLR];
  assign aclr = w_rst && bus.wdata[`RTC_RS_ACLR];
  assign sec_step = tick & cen_r;

  // Month length; leap year assumed whenever the two-bit count is zero
  always_comb begin
    if (month_r == 5'h02) begin
      last_day = (leap_r == 2'h0) ? 6'h29 : 6'h28;
    end else if (month_r == 5'h04 || month_r == 5'h06 || month_r == 5'h09
                 || month_r == 5'h11) begin
      last_day = 6'h30;
    end else begin
      last_day = 6'h31;
    end
  end

  // --------------------------------------------------------------
  // Counting chain, one carry per field
  // --------------------------------------------------------------
  always_comb begin
    logic [7:0] t8;
    t8 = 8'h00;
    sec_nxt = sec_r;
    min_nxt = min_r;
    hour_nxt = hour_r;
    wday_nxt = wday_r;
    date_nxt = date_r;
    month_nxt = month_r;
    year_nxt = year_r;
    leap_nxt = leap_r;
    c_min = 1'b0;
    c_hour = 1'b0;
    c_day = 1'b0;
    c_mon = 1'b0;
    c_year = 1'b0;
    if (sec_step) begin
      if (adj_r) begin
        // Seconds_request_a rounds to the nearest minute
        sec_nxt = 7'h00;
        c_min = (sec_r >= 7'h30);
      end else begin
        t8 = bcd_step({1'b0, sec_r}, 8'h59, 8'h00);
        sec_nxt = t8[6:0];
        c_min = (sec_r == 7'h59);
      end
    end
    if (c_min) begin
      t8 = bcd_step({1'b0, min_r}, 8'h59, 8'h00);
      min_nxt = t8[6:0];
      c_hour = (min_r == 7'h59);
    end
    if (c_hour) begin
      if (h24_r) begin
        // Bit 5 is the twenty-hours digit
        t8 = bcd_step({2'b00, hour_r}, 8'h23, 8'h00);
        hour_nxt = t8[5:0];
        c_day = (hour_r == 6'h23);
      end else if (hour_r[4:0] == 5'h11) begin
        // Bit 5 is the PM flag; 11 wraps to 0 of the other half
        hour_nxt = {~hour_r[5], 5'h00};
        c_day = hour_r[5];
      end else begin
        t8 = bcd_step({3'b000, hour_r[4:0]}, 8'h11, 8'h00);
        hour_nxt = {hour_r[5], t8[4:0]};
      end
    end
    if (c_day) begin
      wday_nxt = (wday_r == 3'h6) ? 3'h0 : wday_r + 3'h1;
      t8 = bcd_step({2'b00, date_r}, {2'b00, last_day}, 8'h01);
      date_nxt = t8[5:0];
      c_mon = (date_r == last_day);
    end
    if (c_mon) begin
      t8 = bcd_step({3'b000, month_r}, 8'h12, 8'h01);
      month_nxt = t8[4:0];
      c_year = (month_r == 5'h12);
    end
    if (c_year) begin
      year_nxt = bcd_step(year_r, 8'h99, 8'h00);
      leap_nxt = leap_r + 2'h1;
    end
  end

  // Alarm fires when the new minute matches every cared-for field
  assign alarm_hit = c_min & aen_r & ien_r
                   & (al_min_r == `RTC_ANY_MIN || al_min_r == min_nxt)
                   & (al_hour_r == `RTC_ANY_HOUR || al_hour_r == hour_nxt)
                   & (al_wday_r == `RTC_ANY_DAY || al_wday_r == wday_nxt)
                   & (al_date_r == `RTC_ANY_DATE || al_date_r == date_nxt);

  // --------------------------------------------------------------
  // Running time: no reset, software must load it first
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    // Software writes win over a count in the same cycle
    sec_r <= (bus.wr && bus.addr == `RTC_IDX_SEC && clk_pg) ? bus.wdata[6:0] : sec_nxt;
    min_r <= (bus.wr && bus.addr == `RTC_IDX_MIN && clk_pg) ? bus.wdata[6:0] : min_nxt;
    hour_r <= (bus.wr && bus.addr == `RTC_IDX_HOUR && clk_pg) ? bus.wdata[5:0] : hour_nxt;
    wday_r <= (bus.wr && bus.addr == `RTC_IDX_DAY && clk_pg) ? bus.wdata[2:0] : wday_nxt;
    date_r <= (bus.wr && bus.addr == `RTC_IDX_DATE && clk_pg) ? bus.wdata[5:0] : date_nxt;
    month_r <= (bus.wr && bus.addr == `RTC_IDX_MONTH && clk_pg) ? bus.wdata[4:0] : month_nxt;
    year_r <= (bus.wr && bus.addr == `RTC_IDX_YEAR && clk_pg) ? bus.wdata : year_nxt;
    leap_r <= (bus.wr && bus.addr == `RTC_IDX_YEAR && !clk_pg) ? bus.wdata[1:0] : leap_nxt;
  end

  // --------------------------------------------------------------
  // Alarm and mode settings: no reset either
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (aclr) begin
      // Alarm clear returns every field to don't care
      al_min_r <= `RTC_ANY_MIN;
      al_hour_r <= `RTC_ANY_HOUR;
      al_wday_r <= `RTC_ANY_DAY;
      al_date_r <= `RTC_ANY_DATE;
    end else if (bus.wr && !clk_pg) begin
      if (bus.addr == `RTC_IDX_MIN) begin
        al_min_r <= bus.wdata[6:0];
      end else if (bus.addr == `RTC_IDX_HOUR) begin
        al_hour_r <= bus.wdata[5:0];
      end else if (bus.addr == `RTC_IDX_DAY) begin
        al_wday_r <= bus.wdata[2:0];
      end else if (bus.addr == `RTC_IDX_DATE) begin
        al_date_r <= bus.wdata[5:0];
      end
    end
    if (bus.wr && !clk_pg && bus.addr == `RTC_IDX_MONTH) begin
      h24_r <= bus.wdata[0];
    end
  end

  // --------------------------------------------------------------
  // Page register
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      page_r <= RTC_CLOCK_PAGE;
      ien_r <= 1'b0;
      aen_r <= 1'b0;
      cen_r <= 1'b0;
    end else if (w_page) begin
      page_r <= rtc_page_t'(bus.wdata[`RTC_PG_PAGE]);
      ien_r <= bus.wdata[`RTC_PG_IEN];
      aen_r <= bus.wdata[`RTC_PG_AEN];
      cen_r <= bus.wdata[`RTC_PG_CEN];
    end
  end

  // Seconds_request_a request waits for the next second; a new request wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adj_r <= 1'b0;
    end else begin
      adj_r <= (w_page & bus.wdata[`RTC_PG_ADJ]) | (adj_r & ~sec_step);
    end
  end

  // --------------------------------------------------------------
  // Reset register: tap disables
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tap_off_r <= `RTC_TAPS_RST;
    end else if (w_rst) begin
      tap_off_r <= {bus.wdata[6], bus.wdata[0], bus.wdata[1], bus.wdata[2], bus.wdata[7]};
    end
  end

  // Tap outputs gated per bit
  for (genvar i = 0; i < 5; i++) begin : g_tap
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        tap_out[i] <= 1'b0;
      end else begin
        tap_out[i] <= taps[i] & ~tap_off_r[i];
      end
    end
  end

  // --------------------------------------------------------------
  // Interrupt status and mask; a set beats a clear
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= 2'h0;
    end else begin
      stat_r <= (stat_r & ~(w_stat ? bus.wdata[1:0] : 2'h0)) | {sec_step, alarm_hit};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= 2'h0;
    end else if (bus.wr && bus.addr == `RTC_IDX_MASK) begin
      mask_r <= bus.wdata[1:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // --------------------------------------------------------------
  // Read mux; every read is a snapshot taken on the strobe edge
  // --------------------------------------------------------------
  always_comb begin
    rd_nxt = 8'h00;
    if (bus.addr == `RTC_IDX_SEC) begin
      rd_nxt = clk_pg ? {1'b0, sec_r} : 8'h00;
    end else if (bus.addr == `RTC_IDX_MIN) begin
      rd_nxt = {1'b0, clk_pg ? min_r : al_min_r};
    end else if (bus.addr == `RTC_IDX_HOUR) begin
      rd_nxt = {2'b00, clk_pg ? hour_r : al_hour_r};
    end else if (bus.addr == `RTC_IDX_DAY) begin
      rd_nxt = {5'h00, clk_pg ? wday_r : al_wday_r};
    end else if (bus.addr == `RTC_IDX_DATE) begin
      rd_nxt = {2'b00, clk_pg ? date_r : al_date_r};
    end else if (bus.addr == `RTC_IDX_MONTH) begin
      rd_nxt = clk_pg ? {3'h0, month_r} : {7'h00, h24_r};
    end else if (bus.addr == `RTC_IDX_YEAR) begin
      rd_nxt = clk_pg ? year_r : {6'h00, leap_r};
    end else if (bus.addr == `RTC_IDX_PAGE) begin
      rd_nxt = {ien_r, 2'b00, adj_r, cen_r, aen_r, 1'b0, page_r};
    end else if (bus.addr == `RTC_IDX_RESET) begin
      // Clear bits always read zero
      rd_nxt = {tap_off_r[0], tap_off_r[4], 3'h0, tap_off_r[1], tap_off_r[2], tap_off_r[3]};
    end else if (bus.addr == `RTC_IDX_STAT) begin
      rd_nxt = {6'h00, stat_r};
    end else if (bus.addr == `RTC_IDX_MASK) begin
      rd_nxt = {6'h00, mask_r};
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= bus.rd ? rd_nxt : 8'h00;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  reset_values_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(rst_n) |-> (page_r == RTC_CLOCK_PAGE && !adj_r && !ien_r
                       && tap_off_r == `RTC_TAPS_RST))
    else $error("control fields not initialised by reset");

  sec_snapshot_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bus.rd && bus.addr == `RTC_IDX_SEC && clk_pg) |=> (rd_data == {1'b0, $past(sec_r)}))
    else $error("seconds read is not the running count");

  sec_bit7_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bus.rd && bus.addr == `RTC_IDX_SEC) |=> !rd_data[7])
    else $error("seconds bit 7 read as one");

  wday_upper_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bus.rd && bus.addr == `RTC_IDX_DAY) |=> (rd_data[7:3] == 5'h00))
    else $error("weekday upper bits not zero");

  mode_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bus.rd && bus.addr == `RTC_IDX_MONTH && !clk_pg) |=> (rd_data == {7'h00, $past(h24_r)}))
    else $error("alarm page mode read wrong");

  page_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bus.wr && bus.addr == `RTC_IDX_MONTH && !clk_pg) |=> (h24_r == $past(bus.wdata[0])))
    else $error("alarm page write missed mode bit");

  pm_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (c_hour && !h24_r && hour_r == 6'h11 && !bus.wr) |=> (hour_r == 6'h20))
    else $error("11 AM did not roll to 0 PM");

  set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (w_stat && bus.wdata[`RTC_ST_SEC] && sec_step) |=> stat_r[`RTC_ST_SEC])
    else $error("status set lost to clear");

  alarm_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (alarm_hit && mask_r[`RTC_ST_ALARM]) |=> irq)
    else $error("unmasked alarm did not raise interrupt");

endmodule

`default_nettype wire

//--- verif/rtc_top_tb_top.sv
// Self-checking testbench of the calendar clock register layer
`timescale 1ns/100ps
`default_nettype none
`include "rtc_regs.svh"

module rtc_top_tb_top;
  import rtc_pkg::*;
  // --------------------------------------------------------------
  // Stimulus and observation signals
  // --------------------------------------------------------------
  logic clk_sys = 1'b0; // System clock
  logic rst_n = 1'b0; // Async reset, low
  rtc_bus_req_t bus = '0; // Register request
  logic osc_in = 1'b0; // Slow oscillator stand-in
  logic [7:0] rd_data; // Read data
  logic [4:0] tap_out; // Divider taps
  logic irq; // Level interrupt
  int errors = 0; // Mismatch count
  int checks_done = 0; // Comparison count
  // Short divider so a second passes in a few dozen cycles
  rtc_top #(.DIV_EDGES(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
    .rd_data(rd_data), .osc_in(osc_in), .tap_out(tap_out), .irq(irq));
  // Rows: index, write value, expected read value
  logic [20:0] rows [10] = '{{`RTC_IDX_SEC, 8'h59, 8'h59}, {`RTC_IDX_MIN, 8'h45, 8'h45},
    {`RTC_IDX_HOUR, 8'h23, 8'h23}, {`RTC_IDX_DAY, 8'h06, 8'h06},
    {`RTC_IDX_DATE, 8'h31, 8'h31}, {`RTC_IDX_MONTH, 8'h12, 8'h12},
    {`RTC_IDX_YEAR, 8'h99, 8'h99}, {5'h03, 8'h5a, 8'h00}, {5'h09, 8'ha5, 8'h00},
    {5'h1f, 8'h3c, 8'h00}};
  // 4 ns period
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // --------------------------------------------------------------
  // Bus tasks and comparison
  // --------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask
  // One-cycle write strobe, then an idle cycle
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask
  // Data stands only in the cycle after the strobe, so sample it there
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    check(rd_data, exp);
  endtask
  // Oscillator edges spread over many system clocks
  task automatic osc_edges(input int n);
    repeat (n) begin
      repeat (8) @(posedge clk_sys);
      osc_in <= 1'b1;
      repeat (8) @(posedge clk_sys);
      osc_in <= 1'b0;
    end
  endtask
  // --------------------------------------------------------------
  // Verdict
  // --------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check({3'h0, tap_out}, 8'h00);
    check({7'h0, irq}, 8'h00);
    rd_chk(`RTC_IDX_PAGE, 8'h00);
    rd_chk(`RTC_IDX_RESET, 8'hc7);
    // Clock page rows, including unmapped indices
    for (int i = 0; i < 10; i++) begin
      wr(rows[i][20:16], rows[i][15:8]);
      rd_chk(rows[i][20:16], rows[i][7:0]);
    end
    // Alarm page reaches its own settings at the shared indices
    wr(`RTC_IDX_PAGE, 8'h01);
    wr(`RTC_IDX_MIN, 8'h30);
    rd_chk(`RTC_IDX_MIN, 8'h30);
    wr(`RTC_IDX_SEC, 8'h11);
    rd_chk(`RTC_IDX_SEC, 8'h00);
    wr(`RTC_IDX_DAY, 8'h03);
    rd_chk(`RTC_IDX_DAY, 8'h03);
    wr(`RTC_IDX_YEAR, 8'h02);
    rd_chk(`RTC_IDX_YEAR, 8'h02);
    wr(`RTC_IDX_MONTH, 8'h00);
    rd_chk(`RTC_IDX_MONTH, 8'h00);
    wr(`RTC_IDX_PAGE, 8'h00);
    rd_chk(`RTC_IDX_MIN, 8'h45);
    rd_chk(`RTC_IDX_MONTH, 8'h12);
    // 12-hour rollover at 11:59:59 AM, second event masked first
    wr(`RTC_IDX_HOUR, 8'h11);
    wr(`RTC_IDX_MIN, 8'h59);
    wr(`RTC_IDX_SEC, 8'h59);
    wr(`RTC_IDX_PAGE, 8'h08);
    osc_edges(4);
    repeat (10) @(posedge clk_sys);
    rd_chk(`RTC_IDX_SEC, 8'h00);
    rd_chk(`RTC_IDX_MIN, 8'h00);
    rd_chk(`RTC_IDX_HOUR, 8'h20);
    rd_chk(`RTC_IDX_STAT, 8'h02);
    check({7'h0, irq}, 8'h00);
    wr(`RTC_IDX_PAGE, 8'h00);
    wr(`RTC_IDX_MASK, 8'h02);
    #1;
    check({7'h0, irq}, 8'h01);
    wr(`RTC_IDX_STAT, 8'h02);
    #1;
    check({7'h0, irq}, 8'h00);
    rd_chk(`RTC_IDX_STAT, 8'h00);
    // Second reset in mid-run: control fields clear, time survives
    wr(`RTC_IDX_PAGE, 8'h85);
    wr(`RTC_IDX_RESET, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(`RTC_IDX_PAGE, 8'h00);
    rd_chk(`RTC_IDX_RESET, 8'hc7);
    rd_chk(`RTC_IDX_MASK, 8'h00);
    rd_chk(`RTC_IDX_MIN, 8'h00);
    rd_chk(`RTC_IDX_HOUR, 8'h20);
    rd_chk(`RTC_IDX_YEAR, 8'h99);
    // Seconds_request_a from 45 s with every alarm field don't care; the status
    // clear lands in the very cycle in which the second sets it again
    wr(`RTC_IDX_RESET, 8'h10);
    wr(`RTC_IDX_SEC, 8'h45);
    wr(`RTC_IDX_MASK, 8'h01);
    wr(`RTC_IDX_PAGE, 8'h9c);
    rd_chk(`RTC_IDX_PAGE, 8'h9c);
    osc_edges(3);
    repeat (8) @(posedge clk_sys);
    osc_in <= 1'b1;
    // Fourth edge ticks four clocks on, when this write strobe is sampled
    repeat (3) @(posedge clk_sys);
    wr(`RTC_IDX_STAT, 8'h02);
    osc_in <= 1'b0;
    rd_chk(`RTC_IDX_SEC, 8'h00);
    rd_chk(`RTC_IDX_MIN, 8'h01);
    rd_chk(`RTC_IDX_MIN, 8'h01);
    rd_chk(`RTC_IDX_PAGE, 8'h8c);
    rd_chk(`RTC_IDX_STAT, 8'h03);
    check({7'h0, irq}, 8'h01);
    end_of_test();
  end
endmodule
`default_nettype wire
